// file: cpuamd_decoder.sv
// instruction fetch and effective address generation for an 8-bit core
// ************************************************************
// Functional notes
// - inherent: operands from opcode only, one byte
// - immediate: address pc+1, pc advances two
// - direct: high byte zero, pc advances two
// - extended: high then low byte, pc+3
// - indexed no offset: index is low address
// - indexed byte offset: carry drives high byte
// - indexed word offset: high plus carry, pc+3
// - relative: signed offset added only when taken
// - bit set/clear: bit from opcode, direct page
// - bit test branch: test direct byte, branch pc+3
// - tested bit copied into carry flag
// - instructions are one to three bytes
// - bit opcodes encode bit number times two
// ************************************************************
`timescale 1ns/1ps
`default_nettype none

module cpuamd_decoder
  import cpuamd_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // memory address space
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  input  wire logic [7:0]  mem_rdata,
  // core state
  input  wire logic [7:0]  index_x,
  input  wire logic        branch_cond,
  // decoded instruction to execution
  output logic             exec_valid,
  output logic [7:0]       exec_opcode,
  output cpuamd_mode_e     exec_mode,
  output logic [15:0]      operand_addr,
  output logic             operand_is_mem,
  output logic [2:0]       bit_number,
  output logic             bit_set_not_clear,
  output logic             carry_load,
  output logic             carry_value,
  output logic [15:0]      pc_out
);

  // ************************************************************
  // state
  // ************************************************************
  // sequencer registers
  cpuamd_state_e state_reg, state_next;
  cpuamd_mode_e  mode_reg, mode_next;
  logic [15:0]   pc_reg, pc_next;
  logic [7:0]    opc_reg, opc_next;
  logic [7:0]    op1_reg, op1_next;
  logic [7:0]    op2_reg, op2_next;
  logic [15:0]   ea_reg, ea_next;
  logic          memop_reg, memop_next;
  logic          set_clr_reg, set_clr_next;

  // carry and tested bit
  logic          carry_ld_reg, carry_ld_next;
  logic          carry_val_reg, carry_val_next;
  logic          tbit_reg, tbit_next;

  // registered address bus
  logic [15:0]   addr_reg, addr_next;
  logic          rd_reg, rd_next;

  // decode and operand arithmetic
  logic [1:0]    len;
  cpuamd_mode_e  dec_mode;
  logic          dec_mem;
  logic [8:0]    sum_lo;
  logic [7:0]    ix2_hi;
  logic [15:0]   rel_off;
  logic [7:0]    bit_sel;
  logic          bit_hit;

  // ************************************************************
  // opcode decode
  // ************************************************************
  // mode from upper nibble of the fetched opcode
  always_comb begin
    dec_mem = 1'b1;
    case (mem_rdata[7:4])
      GRP_BTB:            dec_mode = CPUAMD_BTB;
      GRP_BSC:            dec_mode = CPUAMD_BSC;
      GRP_REL:            dec_mode = CPUAMD_REL;
      GRP_DIR, GRP_RDIR:  dec_mode = CPUAMD_DIR;
      GRP_IX1, GRP_RIX1:  dec_mode = CPUAMD_IX1;
      GRP_IX, GRP_RIX:    dec_mode = CPUAMD_IX;
      GRP_IMM: begin
        dec_mode = CPUAMD_IMM;
        // branch to subroutine sits in the immediate column
        if (mem_rdata[3:0] == 4'hD) begin
          dec_mode = CPUAMD_REL;
        end
      end
      GRP_EXT:            dec_mode = CPUAMD_EXT;
      GRP_IX2:            dec_mode = CPUAMD_IX2;
      default: begin
        dec_mode = CPUAMD_INH;
        dec_mem  = 1'b0;
      end
    endcase
  end

  // instruction length per mode
  always_comb begin
    case (mode_reg)
      CPUAMD_INH, CPUAMD_IX:                len = LEN_ONE;
      CPUAMD_EXT, CPUAMD_IX2, CPUAMD_BTB:   len = LEN_THREE;
      default:                              len = LEN_TWO;
    endcase
  end

  // ************************************************************
  // operand arithmetic
  // ************************************************************
  // index plus the offset byte now on the bus: first byte for the
  // byte offset form, second byte for the word offset form
  assign sum_lo  = {1'b0, index_x} + {1'b0, mem_rdata};
  // high byte of the word offset form takes the carry of the low sum
  assign ix2_hi  = op1_reg + {7'h00, sum_lo[8]};
  // branch offset sign extended to the pc width
  assign rel_off = {{8{op2_reg[7]}}, op2_reg};

  // one select per data bit picks the tested bit of the byte on the bus
  for (genvar g = 0; g < 8; g++) begin : g_bit_sel
    assign bit_sel[g] = mem_rdata[g] & (opc_reg[3:BITNUM_LSB] == 3'(g));
  end
  assign bit_hit = |bit_sel;

  // ************************************************************
  // fetch sequencer
  // ************************************************************
  // fetch sequencer next state
  always_comb begin
    state_next     = state_reg;
    mode_next      = mode_reg;
    pc_next        = pc_reg;
    opc_next       = opc_reg;
    op1_next       = op1_reg;
    op2_next       = op2_reg;
    ea_next        = ea_reg;
    memop_next     = memop_reg;
    set_clr_next   = set_clr_reg;
    carry_ld_next  = 1'b0;
    carry_val_next = carry_val_reg;
    tbit_next      = tbit_reg;
    case (state_reg)
      CPUAMD_S_OPC: begin
        opc_next   = mem_rdata;
        mode_next  = dec_mode;
        memop_next = dec_mem;
        set_clr_next = ~mem_rdata[POLAR_BIT];
        if (dec_mode == CPUAMD_INH) begin
          state_next = CPUAMD_S_EXEC;
        end else if (dec_mode == CPUAMD_IX) begin
          ea_next    = {BYTE_ZERO, index_x};
          state_next = CPUAMD_S_EXEC;
        end else begin
          state_next = CPUAMD_S_OP1;
        end
      end
      CPUAMD_S_OP1: begin
        op1_next   = mem_rdata;
        state_next = CPUAMD_S_EXEC;
        case (mode_reg)
          CPUAMD_IMM: ea_next = pc_reg + {14'h0000, LEN_ONE};
          CPUAMD_DIR, CPUAMD_BSC: ea_next = {BYTE_ZERO, mem_rdata};
          CPUAMD_IX1: ea_next = {7'h00, sum_lo[8], sum_lo[7:0]};
          CPUAMD_REL: op2_next = mem_rdata;
          CPUAMD_EXT, CPUAMD_IX2: state_next = CPUAMD_S_OP2;
          CPUAMD_BTB: begin
            ea_next    = {BYTE_ZERO, mem_rdata};
            state_next = CPUAMD_S_OP2;
          end
          default: ea_next = ea_reg;
        endcase
      end
      CPUAMD_S_OP2: begin
        op2_next   = mem_rdata;
        state_next = CPUAMD_S_EXEC;
        if (mode_reg == CPUAMD_EXT) begin
          ea_next = {op1_reg, mem_rdata};
        end else if (mode_reg == CPUAMD_IX2) begin
          ea_next = {ix2_hi, sum_lo[7:0]};
        end else begin
          state_next = CPUAMD_S_TEST;
        end
      end
      CPUAMD_S_TEST: begin
        // tested byte is on the bus now; carry follows the bit
        carry_ld_next  = 1'b1;
        carry_val_next = bit_hit;
        tbit_next      = bit_hit ^ opc_reg[POLAR_BIT];
        state_next     = CPUAMD_S_EXEC;
      end
      CPUAMD_S_EXEC: begin
        state_next = CPUAMD_S_OPC;
        pc_next    = pc_reg + {14'h0000, len};
        // taken branches add the signed offset to the next opcode address
        if (mode_reg == CPUAMD_REL && branch_cond) begin
          pc_next = pc_reg + {14'h0000, LEN_TWO} + rel_off;
        end else if (mode_reg == CPUAMD_BTB && tbit_reg) begin
          pc_next = pc_reg + {14'h0000, LEN_THREE} + rel_off;
        end
      end
      default: state_next = CPUAMD_S_OPC;
    endcase
  end

  // ************************************************************
  // sequencer registers
  // ************************************************************
  // register the sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg     <= CPUAMD_S_OPC;
      mode_reg      <= CPUAMD_INH;
      pc_reg        <= PC_RESET;
      opc_reg       <= BYTE_ZERO;
      op1_reg       <= BYTE_ZERO;
      op2_reg       <= BYTE_ZERO;
      ea_reg        <= 16'h0000;
      memop_reg     <= 1'b0;
      set_clr_reg   <= 1'b1;
      carry_ld_reg  <= 1'b0;
      carry_val_reg <= 1'b0;
      tbit_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      mode_reg      <= mode_next;
      pc_reg        <= pc_next;
      opc_reg       <= opc_next;
      op1_reg       <= op1_next;
      op2_reg       <= op2_next;
      ea_reg        <= ea_next;
      memop_reg     <= memop_next;
      set_clr_reg   <= set_clr_next;
      carry_ld_reg  <= carry_ld_next;
      carry_val_reg <= carry_val_next;
      tbit_reg      <= tbit_next;
    end
  end

  // ************************************************************
  // address bus
  // ************************************************************
  // address for the coming state: fetch bytes from pc, tested byte
  // from the direct page, operand address while executing
  always_comb begin
    addr_next = ea_next;
    rd_next   = 1'b1;
    case (state_next)
      CPUAMD_S_OPC:  addr_next = pc_next;
      CPUAMD_S_OP1:  addr_next = pc_next + {14'h0000, LEN_ONE};
      CPUAMD_S_OP2:  addr_next = pc_next + {14'h0000, LEN_TWO};
      CPUAMD_S_TEST: addr_next = ea_next;
      default: begin
        addr_next = ea_next;
        rd_next   = 1'b0;
      end
    endcase
  end

  // register the bus so the address leaves a flip-flop
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr_reg <= PC_RESET;
      rd_reg   <= 1'b1;
    end else begin
      addr_reg <= addr_next;
      rd_reg   <= rd_next;
    end
  end

  assign mem_addr = addr_reg;
  assign mem_rd   = rd_reg;

  // ************************************************************
  // decoded outputs
  // ************************************************************
  // instruction identity, valid for the one execute cycle
  assign exec_valid        = (state_reg == CPUAMD_S_EXEC);
  assign exec_opcode       = opc_reg;
  assign exec_mode         = mode_reg;

  // operand location
  assign operand_addr      = ea_reg;
  assign operand_is_mem    = memop_reg;

  // bit fields of the bit manipulation forms
  assign bit_number        = opc_reg[3:BITNUM_LSB];
  assign bit_set_not_clear = set_clr_reg;

  // carry flag update and program counter
  assign carry_load        = carry_ld_reg;
  assign carry_value       = carry_val_reg;
  assign pc_out            = pc_reg;

endmodule // cpuamd_decoder

`default_nettype wire

// file: cpuamd_pkg.sv
// package of constants for the cpu addressing mode decoder
package cpuamd_pkg;

  // ************************************************************
  // opcode upper nibble groups
  // ************************************************************
  localparam logic [3:0] GRP_BTB   = 4'h0;
  localparam logic [3:0] GRP_BSC   = 4'h1;
  localparam logic [3:0] GRP_REL   = 4'h2;
  localparam logic [3:0] GRP_DIR   = 4'h3;
  localparam logic [3:0] GRP_INHA  = 4'h4;
  localparam logic [3:0] GRP_INHX  = 4'h5;
  localparam logic [3:0] GRP_IX1   = 4'h6;
  localparam logic [3:0] GRP_IX    = 4'h7;
  localparam logic [3:0] GRP_CTL0  = 4'h8;
  localparam logic [3:0] GRP_CTL1  = 4'h9;
  localparam logic [3:0] GRP_IMM   = 4'hA;
  localparam logic [3:0] GRP_RDIR  = 4'hB;
  localparam logic [3:0] GRP_EXT   = 4'hC;
  localparam logic [3:0] GRP_IX2   = 4'hD;
  localparam logic [3:0] GRP_RIX1  = 4'hE;
  localparam logic [3:0] GRP_RIX   = 4'hF;

  // ************************************************************
  // lengths, field positions and reset values
  // ************************************************************
  localparam logic [1:0]  LEN_ONE    = 2'h1;
  localparam logic [1:0]  LEN_TWO    = 2'h2;
  localparam logic [1:0]  LEN_THREE  = 2'h3;
  localparam int          BITNUM_LSB = 1;
  localparam int          POLAR_BIT  = 0;
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;

  // addressing modes
  typedef enum logic [3:0] {
    CPUAMD_INH, CPUAMD_IMM, CPUAMD_DIR, CPUAMD_EXT, CPUAMD_IX,
    CPUAMD_IX1, CPUAMD_IX2, CPUAMD_REL, CPUAMD_BSC, CPUAMD_BTB
  } cpuamd_mode_e;

  // fetch sequencer states
  typedef enum logic [2:0] {
    CPUAMD_S_OPC, CPUAMD_S_OP1, CPUAMD_S_OP2, CPUAMD_S_TEST, CPUAMD_S_EXEC
  } cpuamd_state_e;

endpackage : cpuamd_pkg

// file: cpuamd_decoder_sva.sv
// assertion checker for the addressing mode decoder
`timescale 1ns/1ps
`default_nettype none
module cpuamd_decoder_sva
  import cpuamd_pkg::*;
(
  // clock and reset
  input wire logic         sys_clk,
  input wire logic         srst,
  // memory and core side
  input wire logic [15:0]  mem_addr,
  input wire logic         mem_rd,
  input wire logic [7:0]   index_x,
  // decoded side
  input wire logic         exec_valid,
  input wire logic [7:0]   exec_opcode,
  input wire cpuamd_mode_e exec_mode,
  input wire logic [15:0]  operand_addr,
  input wire logic [2:0]   bit_number,
  input wire logic         carry_load,
  input wire logic         carry_value,
  input wire logic [15:0]  pc_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ****
  // timing and address relations
  // ****
  a_valid_one_cycle: assert property (exec_valid |=> !exec_valid)
    else $error("exec valid longer than one cycle");
  a_fetch_resumes: assert property (exec_valid |-> !mem_rd ##1 mem_rd && mem_addr == pc_out)
    else $error("fetch does not resume at new pc");
  a_imm_next_byte: assert property (exec_valid && exec_mode == CPUAMD_IMM
    |-> operand_addr == pc_out + 16'h0001)
    else $error("immediate address wrong");
  a_page_zero: assert property (exec_valid && exec_mode inside {CPUAMD_DIR, CPUAMD_BSC}
    |-> operand_addr[15:8] == 8'h00)
    else $error("direct page high byte not zero");
  a_ix_from_index: assert property (exec_valid && exec_mode == CPUAMD_IX
    |-> operand_addr == {8'h00, index_x})
    else $error("indexed address wrong");
  a_long_pc_step: assert property (exec_valid && exec_mode inside {CPUAMD_EXT, CPUAMD_IX2}
    |=> pc_out == $past(pc_out) + 16'h0003)
    else $error("three byte pc step wrong");
  a_short_pc_step: assert property (exec_valid && exec_mode inside {CPUAMD_INH, CPUAMD_IX}
    |=> pc_out == $past(pc_out) + 16'h0001)
    else $error("one byte pc step wrong");
  a_carry_btb_only: assert property (carry_load |-> exec_valid && exec_mode == CPUAMD_BTB)
    else $error("carry loaded outside bit test");
  a_btb_not_taken: assert property (carry_load && carry_value == exec_opcode[0]
    |=> pc_out == $past(pc_out) + 16'h0003)
    else $error("untaken bit test pc wrong");
  a_bit_from_opcode: assert property (exec_valid && exec_mode inside {CPUAMD_BSC, CPUAMD_BTB}
    |-> bit_number == exec_opcode[3:1])
    else $error("bit number wrong");
  a_mode_from_nibble: assert property (exec_valid && exec_opcode[7:4] == GRP_BSC
    |-> exec_mode == CPUAMD_BSC)
    else $error("bit set clear mode wrong");
endmodule // cpuamd_decoder_sva

bind cpuamd_decoder cpuamd_decoder_sva i_sva (.sys_clk, .srst, .mem_addr, .mem_rd, .index_x,
  .exec_valid, .exec_opcode, .exec_mode, .operand_addr, .bit_number, .carry_load,
  .carry_value, .pc_out);
`default_nettype wire

// file: cpuamd_mem.sv
// memory model answering the decoder's address bus
`timescale 1ns/1ps
`default_nettype none
module cpuamd_mem (
  // address side
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  // data side
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [0:65535];
  // fill with one byte no-operations so a stray fetch stays harmless
  initial foreach (mem[a]) mem[a] = 8'h9D;
  // same cycle read, an idle bus shows the inverted byte
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
endmodule // cpuamd_mem
`default_nettype wire

// file: testbench.sv
// self-checking bench for the addressing mode decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cpuamd_pkg::*;
  logic         sys_clk, srst, mem_rd, branch_cond, exec_valid, operand_is_mem;
  logic         bit_set_not_clear, carry_load, carry_value;
  logic [7:0]   mem_rdata, index_x, exec_opcode;
  logic [15:0]  mem_addr, operand_addr, pc_out;
  logic [2:0]   bit_number;
  cpuamd_mode_e exec_mode;
  logic [15:0]  pc = 16'h0000;
  int           err_total = 0;
  int           checks = 0;
  int           cycles = 0;
  cpuamd_decoder i_dut (.sys_clk, .srst, .mem_addr, .mem_rd, .mem_rdata, .index_x,
    .branch_cond, .exec_valid, .exec_opcode, .exec_mode, .operand_addr, .operand_is_mem,
    .bit_number, .bit_set_not_clear, .carry_load, .carry_value, .pc_out);
  cpuamd_mem i_mem (.mem_addr, .mem_rd, .mem_rdata);
  // ****
  // clock, hang limit and helpers
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // place one instruction at pc, run it, judge mode, address, bit fields and next pc
  task automatic step(input logic [7:0] op, b1, b2, input cpuamd_mode_e m,
                      input logic [15:0] ea, nxt, input logic [2:0] eb, input logic ec);
    i_mem.mem[pc] = op;
    i_mem.mem[pc + 16'h0001] = b1;
    i_mem.mem[pc + 16'h0002] = b2;
    for (int n = 0; n < 8 && exec_valid !== 1'b1; n++) @(posedge sys_clk) #1;
    cmp({15'h0000, exec_valid}, 16'h0001);
    cmp(16'(exec_mode), 16'(m));
    cmp({8'h00, exec_opcode}, {8'h00, op});
    cmp({15'h0000, operand_is_mem}, {15'h0000, m != CPUAMD_INH});
    if (!(m inside {CPUAMD_INH, CPUAMD_REL})) cmp(operand_addr, ea);
    if (m inside {CPUAMD_BSC, CPUAMD_BTB}) cmp(16'(bit_number), 16'(eb));
    if (m == CPUAMD_BSC) cmp({15'h0000, bit_set_not_clear}, {15'h0000, ~op[0]});
    if (m == CPUAMD_BTB) cmp({14'h0000, carry_load, carry_value}, {14'h0000, 1'b1, ec});
    @(posedge sys_clk) #1;
    cmp(pc_out, nxt);
    pc = nxt;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_short();
    index_x = 8'hF0;
    step(8'h4C, 8'h00, 8'h00, CPUAMD_INH, 16'h0000, pc + 16'h1, 3'h0, 1'b0);
    step(8'hF6, 8'h00, 8'h00, CPUAMD_IX, 16'h00F0, pc + 16'h1, 3'h0, 1'b0);
  endtask
  task automatic t_two();
    step(8'hA6, 8'h55, 8'h00, CPUAMD_IMM, pc + 16'h1, pc + 16'h2, 3'h0, 1'b0);
    step(8'hB6, 8'h80, 8'h00, CPUAMD_DIR, 16'h0080, pc + 16'h2, 3'h0, 1'b0);
    index_x = 8'hFF;
    step(8'hE6, 8'hFF, 8'h00, CPUAMD_IX1, 16'h01FE, pc + 16'h2, 3'h0, 1'b0);
  endtask
  task automatic t_three();
    step(8'hC6, 8'h12, 8'h34, CPUAMD_EXT, 16'h1234, pc + 16'h3, 3'h0, 1'b0);
    index_x = 8'h20;
    step(8'hD6, 8'h12, 8'hF0, CPUAMD_IX2, 16'h1310, pc + 16'h3, 3'h0, 1'b0);
  endtask
  task automatic t_bits();
    for (int n = 0; n < 16; n++)
      step(8'h10 + 8'(n), 8'hC0 + 8'(n), 8'h00, CPUAMD_BSC, 16'h00C0 + 16'(n), pc + 16'h2,
           3'(n / 2), 1'b0);
  endtask
  task automatic t_test_branch();
    logic b;
    i_mem.mem[16'h00F8] = 8'hA5;
    for (int n = 0; n < 16; n++) begin
      b = i_mem.mem[16'h00F8][n / 2];
      step(8'(n), 8'hF8, 8'h04, CPUAMD_BTB, 16'h00F8, pc + 16'h3 + ((b != n[0]) ? 16'h4 : 16'h0),
           3'(n / 2), b);
    end
  endtask
  task automatic t_rel();
    branch_cond = 1'b1;
    step(8'h20, 8'h80, 8'h00, CPUAMD_REL, 16'h0000, pc - 16'h007E, 3'h0, 1'b0);
    branch_cond = 1'b0;
    step(8'h20, 8'h7F, 8'h00, CPUAMD_REL, 16'h0000, pc + 16'h2, 3'h0, 1'b0);
  endtask
  initial begin
    srst = 1'b1;
    index_x = 8'h00;
    branch_cond = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 srst = 1'b0;
    cmp(pc_out, PC_RESET);
    cmp(mem_addr, PC_RESET);
    cmp({15'h0000, mem_rd}, 16'h0001);
    t_short();
    t_two();
    t_three();
    t_bits();
    t_test_branch();
    t_rel();
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
